/* design/cvr_pkg.sv */
`default_nettype none
package cvr_pkg;
    // register index and field layout
    localparam logic [5:0] REG_INDEX     = 6'h0c;
    localparam int         CODE_LSB      = 0;
    localparam int         CODE_W        = 6;
    localparam int         RANGE_BIT     = 6;
    localparam int         WIDE_BIT      = 7;
    localparam int         OPND_W        = 8;
    localparam int         DQ_W          = 16;
    // reset values and legal code limit
    localparam logic [5:0] CODE_RESET    = 6'h0d;
    localparam logic       RANGE_RESET   = 1'b1;
    localparam logic       WIDE_RESET    = 1'b0;
    localparam logic [5:0] CODE_MAX      = 6'h32;
    localparam int         NUM_SP        = 2;
endpackage
`default_nettype wire

/* design/cvr_sp_copy.sv */
`default_nettype none
// one set point copy of the register operand
module cvr_sp_copy #(
    parameter bit WIDE_EN = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] value
);
    logic [5:0] code_q;
    logic       range_q;
    logic       wide_q;

    // hold until overwritten or reset
    always_ff @(posedge clk) begin
        if (srst) begin
            code_q  <= cvr_pkg::CODE_RESET;
            range_q <= cvr_pkg::RANGE_RESET;
            wide_q  <= cvr_pkg::WIDE_RESET;
        end else if (wr_en) begin
            code_q  <= wr_data[cvr_pkg::CODE_LSB +: cvr_pkg::CODE_W];
            range_q <= wr_data[cvr_pkg::RANGE_BIT];
            wide_q  <= WIDE_EN ? wr_data[cvr_pkg::WIDE_BIT] : 1'b0;
        end
    end

    // top bit exists only in byte-mode builds
    assign value = {wide_q & WIDE_EN, range_q, code_q};
endmodule
`default_nettype wire

/* design/cvr_read_mux.sv */
`default_nettype none
// registered read data onto the dq lines
module cvr_read_mux (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_value,
    output logic      [15:0] dq_out,
    output logic             dq_oe
);
    // unused lanes forced to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            dq_out <= 16'h0000;
            dq_oe  <= 1'b0;
        end else begin
            dq_oe  <= rd_en;
            dq_out <= rd_en ? {8'h00, rd_value} : 16'h0000;
        end
    end
endmodule
`default_nettype wire

/* design/cvr_ca_vref_reg.sv */
`default_nettype none
module cvr_ca_vref_reg #(
    parameter bit WIDE_EN = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        mode_register_write_cmd,
    input  wire logic        mode_register_read_cmd,
    input  wire logic [5:0]  mode_register_index,
    input  wire logic [7:0]  register_operand,
    input  wire logic        write_set_point_select,
    input  wire logic        operating_set_point_select,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    output logic      [5:0]  ca_reference_setting_code,
    output logic             ca_reference_range_select,
    output logic             code_reserved
);
    logic       hit;
    logic [7:0] sp_value [cvr_pkg::NUM_SP];
    logic [7:0] rd_value;
    logic [7:0] op_value;

    // steering below serves exactly two copies, refuse anything else
    if (cvr_pkg::NUM_SP != 2) begin : g_bad_sp
        $error("exactly two set point copies are supported");
    end

    // address decode
    assign hit = (mode_register_index == cvr_pkg::REG_INDEX);

    // one copy per set point, write steered by select bit
    for (genvar i = 0; i < cvr_pkg::NUM_SP; i++) begin : g_sp
        cvr_sp_copy #(.WIDE_EN(WIDE_EN)) u_copy (
            .clk     (clk),
            .srst    (srst),
            .wr_en   (mode_register_write_cmd & hit &
                      (write_set_point_select == 1'(i))),
            .wr_data (register_operand),
            .value   (sp_value[i])
        );
    end

    // reads follow write select, operation follows operating select
    assign rd_value = sp_value[write_set_point_select];
    assign op_value = sp_value[operating_set_point_select];

    cvr_read_mux u_rd (
        .clk      (clk),
        .srst     (srst),
        .rd_en    (mode_register_read_cmd & hit),
        .rd_value (rd_value),
        .dq_out   (dq_out),
        .dq_oe    (dq_oe)
    );

    // operating outputs registered; reserved codes only flagged
    always_ff @(posedge clk) begin
        if (srst) begin
            ca_reference_setting_code <= cvr_pkg::CODE_RESET;
            ca_reference_range_select <= cvr_pkg::RANGE_RESET;
            code_reserved             <= 1'b0;
        end else begin
            ca_reference_setting_code <= op_value[5:0];
            ca_reference_range_select <= op_value[cvr_pkg::RANGE_BIT];
            code_reserved <= (op_value[5:0] > cvr_pkg::CODE_MAX);
        end
    end

    a_read_lane: assert property (@(posedge clk) disable iff (srst)
        mode_register_read_cmd && hit |=> dq_oe && dq_out[15:8] == 8'h00
        && dq_out[7:0] == $past(rd_value))
        else $error("read data wrong");
    a_idle_zero: assert property (@(posedge clk) disable iff (srst)
        !dq_oe |-> dq_out == 16'h0000)
        else $error("idle dq not zero");
    a_wide_zero: assert property (@(posedge clk) disable iff (srst)
        !WIDE_EN && dq_oe |-> !dq_out[7])
        else $error("bit 7 not zero");
    a_write_take: assert property (@(posedge clk) disable iff (srst)
        mode_register_write_cmd && hit && !mode_register_read_cmd
        ##1 mode_register_read_cmd && hit && !mode_register_write_cmd
        && $stable(write_set_point_select)
        |=> dq_out[6:0] == $past(register_operand[6:0], 2))
        else $error("write not stored");
    a_reset_code: assert property (@(posedge clk)
        $past(srst) |-> ca_reference_setting_code == cvr_pkg::CODE_RESET
        && ca_reference_range_select)
        else $error("bad reset value");
    a_op_follow: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> ca_reference_setting_code == $past(op_value[5:0]))
        else $error("operating copy wrong");
    a_inactive_hold: assert property (@(posedge clk) disable iff (srst)
        mode_register_write_cmd && hit && write_set_point_select
        != operating_set_point_select && $stable(operating_set_point_select)
        |=> ##1 $stable(ca_reference_setting_code))
        else $error("inactive write disturbed");
    a_no_hit: assert property (@(posedge clk) disable iff (srst)
        mode_register_read_cmd && !hit |=> !dq_oe)
        else $error("wrong index answered");

    // status flag must track the operating code, legal or not
    a_reserved_flag: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> code_reserved == ($past(op_value[5:0]) > cvr_pkg::CODE_MAX))
        else $error("reserved flag wrong");
    a_range_follow: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> ca_reference_range_select
        == $past(op_value[cvr_pkg::RANGE_BIT]))
        else $error("operating range wrong");

    // read lane only answers a read hit, one cycle per strobe
    a_oe_pulse: assert property (@(posedge clk) disable iff (srst)
        !(mode_register_read_cmd && hit) |=> !dq_oe)
        else $error("unrequested read answer");
    a_upper_zero: assert property (@(posedge clk) disable iff (srst)
        dq_oe |-> dq_out[15:8] == 8'h00)
        else $error("upper lanes not zero");

    // copies keep their value unless their own write arrives
    a_hold_sp0: assert property (@(posedge clk) disable iff (srst)
        !(mode_register_write_cmd && hit && !write_set_point_select)
        |=> $stable(sp_value[0]))
        else $error("copy 0 changed");
    a_hold_sp1: assert property (@(posedge clk) disable iff (srst)
        !(mode_register_write_cmd && hit && write_set_point_select)
        |=> $stable(sp_value[1]))
        else $error("copy 1 changed");

    // a write lands only in the write-selected copy
    a_write_sp0: assert property (@(posedge clk) disable iff (srst)
        mode_register_write_cmd && hit && !write_set_point_select
        |=> sp_value[0][6:0] == $past(register_operand[6:0]))
        else $error("copy 0 write lost");
    a_write_sp1: assert property (@(posedge clk) disable iff (srst)
        mode_register_write_cmd && hit && write_set_point_select
        |=> sp_value[1][6:0] == $past(register_operand[6:0]))
        else $error("copy 1 write lost");

    // top bit never stored outside byte-mode builds
    a_wide_store: assert property (@(posedge clk) disable iff (srst)
        !WIDE_EN |-> !sp_value[0][7] && !sp_value[1][7])
        else $error("bit 7 stored");
endmodule
`default_nettype wire

/* verification/cvr_ctrl_model.sv */
`default_nettype none
// controller side: one command per call, launched after a falling edge
module cvr_ctrl_model (
    input  wire logic       clk,
    output logic            wr,
    output logic            rd,
    output logic      [5:0] idx,
    output logic      [7:0] opnd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        idx = 6'h00;
        opnd = 8'h00;
    end
    // held a full cycle so the rising edge in between takes it
    task automatic cmd(input logic w, input logic r, input logic [5:0] a,
                       input logic [7:0] v);
        wr = w;
        rd = r;
        idx = a;
        opnd = v;
        @(negedge clk);
    endtask
    // inverted idle values, stale data never looks valid
    task automatic idle();
        wr = 1'b0;
        rd = 1'b0;
        idx = ~idx;
        opnd = ~opnd;
    endtask
endmodule
`default_nettype wire

/* verification/cvr_ca_vref_reg_tb.sv */
`default_nettype none
module cvr_ca_vref_reg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1, ws = 1'b0, os = 1'b0;
    logic        wr, rd, dq_oe, rng, rsv;
    logic [5:0]  idx, code, a;
    logic [7:0]  opnd, v;
    logic [15:0] dq;
    logic [7:0]  sp [2];
    logic [15:0] exp_q [$];
    int          mismatches = 0, n_tests = 0, cyc = 0;
    integer      seed = 32'h73c9;
    cvr_ctrl_model u_ctrl (.clk(clk), .wr(wr), .rd(rd), .idx(idx),
                           .opnd(opnd));
    cvr_ca_vref_reg dut (.clk(clk), .srst(srst),
        .mode_register_write_cmd(wr), .mode_register_read_cmd(rd),
        .mode_register_index(idx), .register_operand(opnd),
        .write_set_point_select(ws), .operating_set_point_select(os),
        .dq_out(dq), .dq_oe(dq_oe), .ca_reference_setting_code(code),
        .ca_reference_range_select(rng), .code_reserved(rsv));
    initial forever #20 clk = ~clk;
    task automatic check(input logic [15:0] got, input logic [15:0] ex);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // answers are checked once the edge has settled
    always @(posedge clk) begin
        #1;
        if (dq_oe === 1'b1) check(dq, exp_q.pop_front());
    end
    // hang guard, the run needs about 170 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        sp[0] = 8'h4d;
        sp[1] = 8'h4d;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        for (int i = 0; i < 60; i++) begin
            os = $random(seed);
            ws = $random(seed);
            a = ($random(seed) & 3) ? 6'h0c : 6'($random(seed));
            v = $random(seed);
            if (v[5:0] > 6'h32) v[5:0] = v[5:0] - 6'h33;
            if (i % 3 != 2) begin
                if (a == 6'h0c) sp[ws] = v & 8'h7f;
                u_ctrl.cmd(1'b1, 1'b0, a, v);
            end
            if (a == 6'h0c) exp_q.push_back({8'h00, sp[ws]});
            u_ctrl.cmd(1'b0, 1'b1, a, 8'h00);
            u_ctrl.idle();
            @(negedge clk);
            check({8'h00, rsv, rng, code}, {9'h000, sp[os][6:0]});
        end
        // mid-run reset brings both copies back to defaults
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        for (int s = 0; s < 2; s++) begin
            ws = s[0];
            exp_q.push_back(16'h004d);
            u_ctrl.cmd(1'b0, 1'b1, 6'h0c, 8'h00);
        end
        u_ctrl.idle();
        os = 1'b0;
        repeat (3) @(negedge clk);
        check({9'h000, rng, code}, 16'h004d);
        check(16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
